// [pkg/wdg_map.vh]
// Purpose: Register map, field positions, reset values and counts of the watchdog.
// Assumes: Included by its bare name from every design file that needs it.
// Notes: Definitions only.
`ifndef WDG_MAP_VH
`define WDG_MAP_VH

// ****************************************
// Register indices and byte address width
// ****************************************
`define WDG_IDX_MODE 16'hff98
`define WDG_IDX_RESTART 16'hff99
`define WDG_IDX_BITOP 16'hff9a
`define WDG_IDX_STATUS 16'hff9b
`define WDG_IDX_MASK 16'hff9c
`define WDG_IDX_STATE 16'hff9d
`define WDG_ADDR_W 18

// ****************************************
// Reset values and key
// ****************************************
`define WDG_MODE_RST 8'h67
`define WDG_RESTART_READ 8'h9a
`define WDG_RESTART_KEY 8'hac

// ****************************************
// Mode register fields
// ****************************************
`define WDG_CLK_SEL_HI 4
`define WDG_CLK_SEL_LO 3
`define WDG_PERIOD_MSB 2
`define WDG_PERIOD_LSB 0

// ****************************************
// Overflow exponents and counter width
// ****************************************
`define WDG_EXP_BASE_LS 5'h0b
`define WDG_EXP_BASE_X1 5'h0d
`define WDG_CNT_W 20

// ****************************************
// Interrupt status bits
// ****************************************
`define WDG_EV_W 4
`define WDG_EV_OVERFLOW 0
`define WDG_EV_VIOLATION 1
`define WDG_EV_RESTART 2
`define WDG_EV_RESUME 3

`endif

// [design/wdg_sync3.v]
// Purpose: Three-stage synchroniser with agreement filter and rising-edge pulse.
// Assumes: The input is asynchronous to pclk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none

module wdg_sync3
(
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // Asynchronous input.
  input wire async_in,
  // Filtered level and its rising edge.
  output reg level_reg,
  output wire rise
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg level_d_reg;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
      level_d_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
      begin
        level_reg <= s3_reg;
      end
      level_d_reg <= level_reg;
    end
  end

  assign rise = level_reg & ~level_d_reg;

endmodule

`default_nettype wire

// [design/wdg_counter.v]
// Purpose: Watchdog up-counter with clear and overflow detection.
// Assumes: inc is a one-cycle enable pulse on pclk.
// Notes: Clear has priority over counting.
`timescale 1ns/100ps
`default_nettype none

module wdg_counter
#(
  parameter WIDTH = 20
)
(
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // Control.
  input wire clr,
  input wire inc,
  input wire [WIDTH-1:0] last,
  // Status.
  output reg [WIDTH-1:0] count_reg,
  output wire overflow
);

  assign overflow = inc & ~clr & (count_reg == last);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_reg <= {WIDTH{1'b0}};
    end
    else if (clr || overflow)
    begin
      count_reg <= {WIDTH{1'b0}};
    end
    else if (inc)
    begin
      count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

// [design/wdg_top.v]
// Purpose: Watchdog timer with selectable count clock and standby freeze.
// Assumes: Count clocks are pins sampled on pclk; standby inputs are pclk logic.
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "wdg_map.vh"
`default_nettype none

module wdg_top
#(
  parameter SETTLE_BASE = 11,
  parameter SETTLE_SEL_W = 3
)
(
  // APB slave.
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`WDG_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // Count clock pins.
  input wire low_speed_clk,
  input wire x1_clk,
  // Standby and clock generator.
  input wire stop_mode,
  input wire halt_mode,
  input wire cpu_on_x1,
  input wire [SETTLE_SEL_W-1:0] osc_settle_select,
  // Reset request and interrupt.
  output reg wdg_reset_reg,
  output wire wdg_irq
);

  // ****************************************
  // Address decode
  // ****************************************
  localparam [`WDG_ADDR_W-1:0] ADDR_MODE = {`WDG_IDX_MODE, 2'b00};
  localparam [`WDG_ADDR_W-1:0] ADDR_RESTART = {`WDG_IDX_RESTART, 2'b00};
  localparam [`WDG_ADDR_W-1:0] ADDR_BITOP = {`WDG_IDX_BITOP, 2'b00};
  localparam [`WDG_ADDR_W-1:0] ADDR_STATUS = {`WDG_IDX_STATUS, 2'b00};
  localparam [`WDG_ADDR_W-1:0] ADDR_MASK = {`WDG_IDX_MASK, 2'b00};
  localparam [`WDG_ADDR_W-1:0] ADDR_STATE = {`WDG_IDX_STATE, 2'b00};
  localparam SETTLE_W = 24;

  reg sel_mode;
  reg sel_restart;
  reg sel_bitop;
  reg sel_status;
  reg sel_mask;
  reg sel_state;
  wire mapped;
  wire setup_ph;
  wire access_ph;
  wire wr_acc;

  always @*
  begin
    sel_mode = 1'b0;
    sel_restart = 1'b0;
    sel_bitop = 1'b0;
    sel_status = 1'b0;
    sel_mask = 1'b0;
    sel_state = 1'b0;
    if (paddr == ADDR_MODE)
      sel_mode = 1'b1;
    else if (paddr == ADDR_RESTART)
      sel_restart = 1'b1;
    else if (paddr == ADDR_BITOP)
      sel_bitop = 1'b1;
    else if (paddr == ADDR_STATUS)
      sel_status = 1'b1;
    else if (paddr == ADDR_MASK)
      sel_mask = 1'b1;
    else if (paddr == ADDR_STATE)
      sel_state = 1'b1;
  end

  assign mapped = sel_mode | sel_restart | sel_bitop | sel_status | sel_mask | sel_state;
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_acc = access_ph & pwrite;
  assign pready = 1'b1;
  assign pslverr = access_ph & ~mapped;

  // ****************************************
  // Count clock sampling
  // ****************************************
  wire ls_level;
  wire ls_rise;
  wire x1_level;
  wire x1_rise;

  wdg_sync3 u_ls_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(low_speed_clk),
    .level_reg(ls_level),
    .rise(ls_rise)
  );

  wdg_sync3 u_x1_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(x1_clk),
    .level_reg(x1_level),
    .rise(x1_rise)
  );

  // ****************************************
  // Mode and access checking
  // ****************************************
  reg [7:0] wdog_mode_reg;
  reg mode_written_reg;
  wire clk_sel_hi;
  wire clk_sel_lo;
  wire [2:0] period_sel;
  wire running;
  wire mode_wr;
  wire restart_wr;
  wire key_ok;
  wire bitop_wr;
  wire violation;

  assign clk_sel_hi = wdog_mode_reg[`WDG_CLK_SEL_HI];
  assign clk_sel_lo = wdog_mode_reg[`WDG_CLK_SEL_LO];
  assign period_sel = wdog_mode_reg[`WDG_PERIOD_MSB:`WDG_PERIOD_LSB];
  assign running = ~clk_sel_hi;
  assign mode_wr = wr_acc & sel_mode;
  assign restart_wr = wr_acc & sel_restart;
  assign key_ok = (pwdata[7:0] == `WDG_RESTART_KEY);
  assign bitop_wr = wr_acc & sel_bitop;
  // Violations only count while the watchdog runs.
  assign violation = running & ((mode_wr & mode_written_reg)
    | (restart_wr & ~key_ok)
    | bitop_wr);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdog_mode_reg <= `WDG_MODE_RST;
      mode_written_reg <= 1'b0;
    end
    else if (mode_wr && !mode_written_reg)
    begin
      wdog_mode_reg <= pwdata[7:0];
      mode_written_reg <= 1'b1;
    end
  end

  // ****************************************
  // Standby freeze and settling wait
  // ****************************************
  reg stop_d_reg;
  reg hold_reg;
  reg cpu_x1_at_stop_reg;
  reg [SETTLE_W-1:0] settle_cnt_reg;
  reg [SETTLE_W-1:0] settle_last;
  wire stop_release;
  wire settle_done;
  wire switch_done;
  wire resume;

  always @*
  begin
    settle_last = {SETTLE_W{1'b0}};
    settle_last[SETTLE_BASE + osc_settle_select] = 1'b1;
    settle_last = settle_last - {{(SETTLE_W-1){1'b0}}, 1'b1};
  end

  assign stop_release = stop_d_reg & ~stop_mode;
  assign settle_done = hold_reg & x1_rise & (settle_cnt_reg == settle_last);
  assign switch_done = hold_reg & ~cpu_x1_at_stop_reg & cpu_on_x1;
  assign resume = settle_done | switch_done;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stop_d_reg <= 1'b0;
      hold_reg <= 1'b0;
      cpu_x1_at_stop_reg <= 1'b0;
      settle_cnt_reg <= {SETTLE_W{1'b0}};
    end
    else
    begin
      stop_d_reg <= stop_mode;
      if (stop_mode && !stop_d_reg)
      begin
        cpu_x1_at_stop_reg <= cpu_on_x1;
      end
      if (stop_release && running && clk_sel_lo)
      begin
        hold_reg <= 1'b1;
        settle_cnt_reg <= {SETTLE_W{1'b0}};
      end
      else if (resume)
      begin
        hold_reg <= 1'b0;
      end
      else if (hold_reg && x1_rise)
      begin
        settle_cnt_reg <= settle_cnt_reg + {{(SETTLE_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ****************************************
  // Counter and overflow
  // ****************************************
  wire tick;
  wire frozen;
  wire cnt_inc;
  wire cnt_clr;
  wire overflow;
  wire [4:0] exp_sel;
  wire [`WDG_CNT_W:0] period_one;
  wire [`WDG_CNT_W-1:0] cnt_last;
  wire [`WDG_CNT_W-1:0] count;

  assign tick = clk_sel_lo ? x1_rise : ls_rise;
  // Low-speed pairings resume straight after release.
  assign frozen = stop_mode | halt_mode | hold_reg;
  assign cnt_inc = running & ~frozen & tick;
  assign cnt_clr = mode_wr | (restart_wr & key_ok);
  assign exp_sel = (clk_sel_lo ? `WDG_EXP_BASE_X1 : `WDG_EXP_BASE_LS) + {2'b00, period_sel};
  assign period_one = {{`WDG_CNT_W{1'b0}}, 1'b1} << exp_sel;
  assign cnt_last = period_one[`WDG_CNT_W-1:0] - {{(`WDG_CNT_W-1){1'b0}}, 1'b1};

  wdg_counter #(.WIDTH(`WDG_CNT_W)) u_counter
  (
    .pclk(pclk),
    .presetn(presetn),
    .clr(cnt_clr),
    .inc(cnt_inc),
    .last(cnt_last),
    .count_reg(count),
    .overflow(overflow)
  );

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdg_reset_reg <= 1'b0;
    end
    else if (overflow || violation)
    begin
      wdg_reset_reg <= 1'b1;
    end
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  reg [`WDG_EV_W-1:0] irq_status_reg;
  reg [`WDG_EV_W-1:0] irq_mask_reg;
  wire [`WDG_EV_W-1:0] events;
  wire [`WDG_EV_W-1:0] w1c;

  assign events[`WDG_EV_OVERFLOW] = overflow;
  assign events[`WDG_EV_VIOLATION] = violation;
  assign events[`WDG_EV_RESTART] = restart_wr & key_ok;
  assign events[`WDG_EV_RESUME] = resume;
  assign w1c = (wr_acc & sel_status) ? pwdata[`WDG_EV_W-1:0] : {`WDG_EV_W{1'b0}};

  genvar gi;
  generate
    for (gi = 0; gi < `WDG_EV_W; gi = gi + 1)
    begin : g_status
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          irq_status_reg[gi] <= 1'b0;
        end
        else if (events[gi])
        begin
          irq_status_reg[gi] <= 1'b1;
        end
        else if (w1c[gi])
        begin
          irq_status_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_mask_reg <= {`WDG_EV_W{1'b0}};
    end
    else if (wr_acc && sel_mask)
    begin
      irq_mask_reg <= pwdata[`WDG_EV_W-1:0];
    end
  end

  assign wdg_irq = |(irq_status_reg & irq_mask_reg);

  // ****************************************
  // Read data
  // ****************************************
  reg [31:0] rd_next;

  always @*
  begin
    rd_next = 32'h0000_0000;
    if (sel_mode)
      rd_next[7:0] = wdog_mode_reg;
    else if (sel_restart)
      rd_next[7:0] = `WDG_RESTART_READ;
    else if (sel_status)
      rd_next[`WDG_EV_W-1:0] = irq_status_reg;
    else if (sel_mask)
      rd_next[`WDG_EV_W-1:0] = irq_mask_reg;
    else if (sel_state)
    begin
      rd_next[`WDG_CNT_W-1:0] = count;
      rd_next[24] = running;
      rd_next[25] = hold_reg;
      rd_next[26] = mode_written_reg;
      rd_next[27] = ls_level;
      rd_next[28] = x1_level;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (setup_ph && !pwrite)
    begin
      prdata <= rd_next;
    end
  end

endmodule

`default_nettype wire

// [tb/wdg_top_chk.sv]
// Purpose: Port assertions for the watchdog.
// Assumes: Bound to wdg_top by the bench.
// Notes: Tracks the one-time mode write to know when the watchdog is stopped.
`timescale 1ns/100ps
`include "wdg_map.vh"
`default_nettype none
module wdg_top_chk
#(
  parameter SETTLE_BASE = 11,
  parameter SETTLE_SEL_W = 3
)
(
  // APB.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`WDG_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // Pins and standby.
  input wire logic low_speed_clk,
  input wire logic x1_clk,
  input wire logic stop_mode,
  input wire logic halt_mode,
  input wire logic cpu_on_x1,
  input wire logic [SETTLE_SEL_W-1:0] osc_settle_select,
  // Outputs.
  input wire logic wdg_reset_reg,
  input wire logic wdg_irq
);
  // ****
  // Decode and tracking
  // ****
  localparam logic [17:0] A_MODE = {`WDG_IDX_MODE, 2'b00};
  localparam logic [17:0] A_RST = {`WDG_IDX_RESTART, 2'b00};
  localparam logic [17:0] A_BIT = {`WDG_IDX_BITOP, 2'b00};
  logic acc;
  logic mapped;
  logic mode_done;
  logic stopped;
  assign acc = psel && penable;
  assign mapped = paddr[17:2] inside {[`WDG_IDX_MODE:`WDG_IDX_STATE]} && paddr[1:0] == 2'b00;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_done <= 1'b0;
      stopped <= 1'b0;
    end
    else if (acc && pwrite && paddr == A_MODE && !mode_done)
    begin
      mode_done <= 1'b1;
      stopped <= pwdata[`WDG_CLK_SEL_HI];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rst;
    ##[1:2] wdg_reset_reg;
  endsequence
  a_slverr_map: assert property (acc |-> pslverr == !mapped)
    else $error("pslverr does not match address decode");
  a_reset_sticky: assert property (wdg_reset_reg |=> wdg_reset_reg)
    else $error("reset request dropped");
  a_key_keeps: assert property (acc && pwrite && paddr == A_RST && pwdata[7:0] == 8'hac
    && !wdg_reset_reg |=> !wdg_reset_reg) else $error("key write raised reset");
  a_wrong_key: assert property (acc && pwrite && paddr == A_RST && pwdata[7:0] != 8'hac
    && !stopped |-> s_rst) else $error("wrong key gave no reset");
  a_bit_access: assert property (acc && pwrite && paddr == A_BIT && !stopped |-> s_rst)
    else $error("bit access gave no reset");
  a_mode_twice: assert property (acc && pwrite && paddr == A_MODE && mode_done
    && !stopped |-> s_rst) else $error("second mode write gave no reset");
  a_stop_quiet: assert property (stopped && !wdg_reset_reg |=> !wdg_reset_reg)
    else $error("reset while stopped");
  a_restart_read: assert property (psel && !penable && !pwrite && paddr == A_RST
    |=> prdata == 32'h9a) else $error("restart register read value wrong");
endmodule
`default_nettype wire

// [tb/wdg_clk_model.sv]
// Purpose: Clock generator model making the two count clocks.
// Assumes: Both rates stay well below the bus clock.
// Notes: The X1 oscillator stands still at low during STOP.
`timescale 1ns/100ps
`default_nettype none
module wdg_clk_model
(
  // Standby.
  input wire logic stop_mode,
  // Count clocks.
  output logic low_speed_clk,
  output logic x1_clk
);
  // ****
  // Oscillators
  // ****
  initial
  begin
    low_speed_clk = 1'b0;
    forever #20 low_speed_clk = ~low_speed_clk;
  end
  initial
  begin
    x1_clk = 1'b0;
    forever #15 x1_clk = stop_mode ? 1'b0 : ~x1_clk;
  end
endmodule
`default_nettype wire

// [tb/watchdog_standby_behaviour_tb.sv]
// Purpose: Self-checking bench for the watchdog.
// Assumes: Settling base reduced to 2 to keep runs short.
// Notes: Each scenario starts from a fresh reset.
`timescale 1ns/100ps
`include "wdg_map.vh"
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module watchdog_standby_behaviour_tb;
  // ****
  // Signals and instances
  // ****
  localparam logic [17:0] A_MODE = {`WDG_IDX_MODE, 2'b00};
  localparam logic [17:0] A_RST = {`WDG_IDX_RESTART, 2'b00};
  localparam logic [17:0] A_BIT = {`WDG_IDX_BITOP, 2'b00};
  localparam logic [17:0] A_STS = {`WDG_IDX_STATUS, 2'b00};
  localparam logic [17:0] A_MSK = {`WDG_IDX_MASK, 2'b00};
  localparam logic [17:0] A_STA = {`WDG_IDX_STATE, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic low_speed_clk, x1_clk, stop_mode, halt_mode, cpu_on_x1, wdg_reset_reg, wdg_irq;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0] osc_settle_select;
  logic [19:0] c0, c1;
  int num_errors, tests_run;
  wdg_top #(.SETTLE_BASE(2)) i_wdg_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .low_speed_clk(low_speed_clk), .x1_clk(x1_clk),
    .stop_mode(stop_mode), .halt_mode(halt_mode), .cpu_on_x1(cpu_on_x1),
    .osc_settle_select(osc_settle_select), .wdg_reset_reg(wdg_reset_reg), .wdg_irq(wdg_irq));
  wdg_clk_model i_wdg_clk_model (.stop_mode(stop_mode), .low_speed_clk(low_speed_clk),
    .x1_clk(x1_clk));
  // ****
  // Tasks
  // ****
  task finish_test;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 20) begin num_errors++; finish_test; end
      @(posedge pclk);
    end
    r = prdata; err = pslverr; psel <= 1'b0; penable <= 1'b0;
  endtask
  task cnt(output logic [19:0] c);
    apb(1'b0, A_STA, 32'h0);
    c = r[19:0];
  endtask
  task rst;
    presetn <= 1'b0; stop_mode <= 1'b0; halt_mode <= 1'b0; cpu_on_x1 <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task irq_is(input logic e);
    @(negedge pclk);
    `CHK(wdg_irq, e)
  endtask
  task t_regs;
    rst;
    apb(1'b0, A_MODE, 32'h0); `CHK(r[7:0], 8'h67)
    apb(1'b0, A_RST, 32'h0); `CHK(r[7:0], 8'h9a)
    apb(1'b0, 18'h3fe80, 32'h0);
    `CHK(err, 1'b1)
    `CHK(r, 32'h0000_0000)
  endtask
  task t_clear;
    rst;
    repeat (200) @(posedge pclk);
    cnt(c0); apb(1'b1, A_MODE, 32'h60); cnt(c1); `CHK(c1 < c0, 1'b1)
    apb(1'b1, A_MSK, 32'h4); repeat (200) @(posedge pclk);
    cnt(c0); apb(1'b1, A_RST, 32'hac); cnt(c1); `CHK(c1 < c0, 1'b1)
    irq_is(1'b1); apb(1'b1, A_MSK, 32'h0); irq_is(1'b0);
    apb(1'b1, A_MSK, 32'h4); irq_is(1'b1); apb(1'b1, A_STS, 32'h4); irq_is(1'b0);
    apb(1'b1, A_RST, 32'hac);
    repeat (2040) @(posedge low_speed_clk);
    `CHK(wdg_reset_reg, 1'b0)
    for (int n = 0; n < 150 && wdg_reset_reg !== 1'b1; n++) @(posedge pclk);
    `CHK(wdg_reset_reg, 1'b1)
    apb(1'b0, A_STS, 32'h0); `CHK(r[0], 1'b1)
  endtask
  task t_viol;
    for (int k = 0; k < 3; k++)
    begin
      rst; apb(1'b1, A_MODE, 32'h60);
      apb(1'b1, k == 0 ? A_MODE : k == 1 ? A_RST : A_BIT, 32'h55);
      repeat (3) @(posedge pclk);
      `CHK(wdg_reset_reg, 1'b1)
      apb(1'b0, A_STS, 32'h0);
      `CHK(r[`WDG_EV_VIOLATION], 1'b1)
    end
    rst; apb(1'b1, A_MODE, 32'h70);
    apb(1'b1, A_MODE, 32'h60); apb(1'b1, A_RST, 32'h55); apb(1'b1, A_BIT, 32'h1);
    repeat (100) @(posedge pclk);
    `CHK(wdg_reset_reg, 1'b0)
    apb(1'b0, A_STS, 32'h0);
    `CHK(r[`WDG_EV_VIOLATION], 1'b0)
    cnt(c0); `CHK(c0, 20'h0)
  endtask
  task t_halt;
    rst; apb(1'b1, A_MODE, 32'h60);
    repeat (100) @(posedge pclk);
    halt_mode <= 1'b1;
    repeat (20) @(posedge pclk);
    cnt(c0); repeat (200) @(posedge pclk); cnt(c1); `CHK(c1, c0)
    halt_mode <= 1'b0;
    repeat (100) @(posedge pclk);
    cnt(c1); `CHK(c1 > c0 && c1 < c0 + 20, 1'b1)
  endtask
  task t_stop(input logic [7:0] m, input logic cpu, input logic [2:0] sel, input logic hold,
    input logic sw);
    rst; cpu_on_x1 <= cpu; osc_settle_select <= sel; apb(1'b1, A_MODE, {24'h0, m});
    repeat (300) @(posedge pclk);
    stop_mode <= 1'b1;
    repeat (10) @(posedge pclk);
    cnt(c0); repeat (200) @(posedge pclk); cnt(c1); `CHK(c1, c0)
    stop_mode <= 1'b0;
    repeat (20) @(posedge pclk);
    cnt(c1); `CHK(c1 == c0, hold)
    if (sw) cpu_on_x1 <= 1'b1;
    repeat (400) @(posedge pclk);
    cnt(c1); `CHK(c1 > c0, 1'b1)
    apb(1'b0, A_STS, 32'h0);
    `CHK(r[`WDG_EV_RESUME], hold)
  endtask
  // ****
  // Clock and main sequence
  // ****
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial
  begin
    #400000;
    num_errors++;
    finish_test;
  end
  initial
  begin
    num_errors = 0; tests_run = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 18'h0; pwdata = 32'h0; stop_mode = 1'b0; halt_mode = 1'b0;
    cpu_on_x1 = 1'b0; osc_settle_select = 3'h0;
    t_regs; t_clear; t_viol; t_halt;
    t_stop(8'h68, 1'b1, 3'h3, 1'b1, 1'b0);
    t_stop(8'h60, 1'b1, 3'h7, 1'b0, 1'b0);
    t_stop(8'h68, 1'b0, 3'h7, 1'b1, 1'b1);
    t_stop(8'h60, 1'b0, 3'h7, 1'b0, 1'b0);
    finish_test;
  end
endmodule
bind wdg_top wdg_top_chk #(.SETTLE_BASE(SETTLE_BASE), .SETTLE_SEL_W(SETTLE_SEL_W)) i_wdg_top_chk
  (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .low_speed_clk(low_speed_clk), .x1_clk(x1_clk), .stop_mode(stop_mode),
  .halt_mode(halt_mode), .cpu_on_x1(cpu_on_x1), .osc_settle_select(osc_settle_select),
  .wdg_reset_reg(wdg_reset_reg), .wdg_irq(wdg_irq));
`default_nettype wire
